/* File: logic/acs_defs.svh */
// Constants of the arctangent sequencer: IEEE-754 double values, bit positions and cycle counts.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_ONE          64'h3ff0000000000000
`define ACS_TWO          64'h4000000000000000
`define ACS_NEG_ONE      64'hbff0000000000000
`define ACS_HALF_PI      64'h3ff921fb54442d18
`define ACS_NEG_HALF_PI  64'hbff921fb54442d18
`define ACS_C19          64'hbdc4d6cc6308553f
`define ACS_C18          64'h3ddffd56fcfd2315
`define ACS_C17          64'hbde880782d99d071
`define ACS_C16          64'h3e0409670cb71218
`define ACS_C15          64'hbe237c8239249b77
`define ACS_C14          64'h3e3f1358ec1d6ac0
`define ACS_C13          64'hbe587cd25f4afbed
`define ACS_C12          64'h3e73d2388b0b8a86
`define ACS_C11          64'hbe9028e921ca6a94
`define ACS_C10          64'h3eaa814997a38d4e
`define ACS_C9           64'hbec5edad9a21fe5f
`define ACS_C8           64'h3ee256e57ba07fae
`define ACS_C7           64'hbeff171f48fdf707
`define ACS_C6           64'h3f1acfa9f95ca0df
`define ACS_C5           64'hbf37a8464221d994
`define ACS_C4           64'h3f558df7a83283c9
`define ACS_C3           64'hbf749b3e2e433683
`define ACS_C2           64'h3f955a300bfb8078
`define ACS_C1           64'hbfba1494c19fadd4
`define ACS_C0           64'h3febda7a85bd40cb
`define ACS_TOP_COEF     5'h13
`define ACS_EXP_BIAS     14'sh03ff
`define ACS_EXP_MAX      14'sh07ff
`define ACS_EXP_LSB      52
`define ACS_DIV_BITS     4
`define ACS_DIV_CYCLES   8'h0f
`define ACS_PIPE_SEL     3'h2
`define ACS_ROUND_NEAREST 2'h0
`define ACS_OP_BUDGET    8'h59
`define ACS_EXTRA_CYCLES 8'h0f
`define ACS_TOTAL_CYCLES (`ACS_OP_BUDGET + `ACS_EXTRA_CYCLES)
`endif

/* File: logic/acs_pkg.sv */
// Types shared by both ends of the arctangent sequencer link.
package acs_pkg;
  typedef enum logic [2:0] {
    acs_op_nop,
    acs_op_cmp_abs,
    acs_op_cmp,
    acs_op_mul,
    acs_op_add,
    acs_op_sub,
    acs_op_div
  } acs_op_t;
  typedef enum logic [1:0] {
    acs_sel_bus,
    acs_sel_res,
    acs_sel_const
  } acs_sel_t;
endpackage : acs_pkg

/* File: logic/acs_link_if.sv */
// Instruction and result link between the sequencing controller and the floating point unit.
interface acs_link_if;
  import acs_pkg::*;
  logic        valid;
  acs_op_t     op;
  acs_sel_t    sel_a;
  acs_sel_t    sel_b;
  logic        load_const;
  logic [63:0] data_a;
  logic [63:0] data_b;
  logic [2:0]  pipeline_stage_select;
  logic [1:0]  rounding_select;
  logic        ready;
  logic        res_valid;
  logic [63:0] result;
  logic        gt;
  logic        lt;
  modport dev (
    input  valid, op, sel_a, sel_b, load_const, data_a, data_b, pipeline_stage_select, rounding_select,
    output ready, res_valid, result, gt, lt
  );
  modport ctl (
    output valid, op, sel_a, sel_b, load_const, data_a, data_b, pipeline_stage_select, rounding_select,
    input  ready, res_valid, result, gt, lt
  );
endinterface : acs_link_if

/* File: logic/acs_fpu_end.sv */
// Double-precision floating point unit end of the arctangent sequencer.
`include "acs_defs.svh"
module acs_fpu_end
  import acs_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  acs_link_if.dev     link,
  output logic [63:0] o_const_reg,
  output logic        o_cfg_err
);
  // Rounds a normalised 56-bit mantissa (hidden bit at 55, guard, round, sticky) and packs it.
  function automatic logic [63:0] acs_pack(input logic s, input logic signed [13:0] e, input logic [55:0] m,
                                           input logic nearest);
    logic               inc;
    logic [53:0]        r;
    logic signed [13:0] ee;
    inc = nearest & m[2] & (m[1] | m[0] | m[3]);
    r = {1'b0, m[55:3]} + {53'h0, inc};
    ee = e;
    if (r[53])
    begin
      r = r >> 1;
      ee = e + 14'sh1;
    end
    if (!m[55] || ee <= 14'sh0)
      return {s, 63'h0};
    if (ee >= `ACS_EXP_MAX)
      return {s, 11'h7ff, 52'h0};
    return {s, ee[10:0], r[51:0]};
  endfunction : acs_pack

  function automatic logic [63:0] acs_mul(input logic [63:0] a, input logic [63:0] b, input logic nearest);
    logic [105:0]       p;
    logic signed [13:0] e;
    logic [55:0]        m;
    p = {1'b1, a[51:0]} * {1'b1, b[51:0]};
    e = $signed({3'h0, a[62:52]}) + $signed({3'h0, b[62:52]}) - `ACS_EXP_BIAS;
    if (p[105])
    begin
      m = {p[105:51], |p[50:0]};
      e = e + 14'sh1;
    end
    else
      m = {p[104:50], |p[49:0]};
    if (a[62:52] == 11'h0 || b[62:52] == 11'h0)
      return {a[63] ^ b[63], 63'h0};
    return acs_pack(a[63] ^ b[63], e, m, nearest);
  endfunction : acs_mul

  function automatic logic [63:0] acs_add(input logic [63:0] a, input logic [63:0] b, input logic nearest);
    logic [63:0]        big;
    logic [63:0]        sml;
    logic [55:0]        mb;
    logic [55:0]        ms;
    logic [10:0]        d;
    logic [56:0]        sum;
    logic [55:0]        m;
    logic signed [13:0] e;
    logic [5:0]         lz;
    big = (a[62:0] >= b[62:0]) ? a : b;
    sml = (a[62:0] >= b[62:0]) ? b : a;
    mb = {big[62:52] != 11'h0, big[51:0], 3'h0};
    ms = {sml[62:52] != 11'h0, sml[51:0], 3'h0};
    d = big[62:52] - sml[62:52];
    if (d > 11'h37)
      ms = {55'h0, |ms};
    else
      ms = (ms >> d) | {55'h0, |(ms & ~({56{1'b1}} << d))};
    sum = (big[63] == sml[63]) ? {1'b0, mb} + {1'b0, ms} : {1'b0, mb} - {1'b0, ms};
    e = $signed({3'h0, big[62:52]});
    lz = 6'h0;
    for (int i = 0; i < 56; i++)
      if (sum[i])
        lz = 6'(55 - i);
    if (sum[56])
    begin
      m = {sum[56:2], sum[1] | sum[0]};
      e = e + 14'sh1;
    end
    else
    begin
      m = sum[55:0] << lz;
      e = e - $signed({8'h0, lz});
    end
    if (sum == 57'h0 || big[62:52] == 11'h0)
      return (big[62:52] == 11'h0) ? 64'h0 : {1'b0, 63'h0};
    return acs_pack(big[63], e, m, nearest);
  endfunction : acs_add

  // Signed ordering key: a plain unsigned compare of keys orders the doubles.
  function automatic logic [63:0] acs_key(input logic [63:0] x);
    return x[63] ? ~x : {1'b1, x[62:0]};
  endfunction : acs_key

  logic [63:0]        constant_holding_register;
  logic [63:0]        opa;
  logic [63:0]        opb;
  logic [63:0]        alu_r;
  logic [63:0]        div_r;
  logic               nearest;
  logic               take;
  logic               pipe_ok;
  logic               cmp_gt;
  logic               cmp_lt;
  logic [7:0]         div_cnt;
  logic [53:0]        rem;
  logic [53:0]        next_rem;
  logic [59:0]        quo;
  logic [59:0]        next_quo;
  logic [52:0]        dvsr;
  logic               dsign;
  logic               dzero;
  logic               dinf;
  logic               dnear;
  logic signed [13:0] dexp;
  logic               div_last;
  logic               div_start;

  assign o_const_reg = constant_holding_register;
  assign opa = (link.sel_a == acs_sel_res) ? link.result :
               (link.sel_a == acs_sel_const) ? constant_holding_register : link.data_a;
  assign opb = (link.sel_b == acs_sel_res) ? link.result :
               (link.sel_b == acs_sel_const) ? constant_holding_register : link.data_b;
  assign take = link.valid & link.ready;
  assign pipe_ok = link.pipeline_stage_select == `ACS_PIPE_SEL;
  assign nearest = link.rounding_select == `ACS_ROUND_NEAREST;
  assign alu_r = (link.op == acs_op_mul) ? acs_mul(opa, opb, nearest) :
                 acs_add(opa, {opb[63] ^ (link.op == acs_op_sub), opb[62:0]}, nearest);
  assign cmp_gt = (link.op == acs_op_cmp_abs) ? (opa[62:0] > opb[62:0]) : (acs_key(opa) > acs_key(opb));
  assign cmp_lt = (link.op == acs_op_cmp_abs) ? (opa[62:0] < opb[62:0]) : (acs_key(opa) < acs_key(opb));
  assign div_last = div_cnt == 8'h1;
  assign div_start = take & pipe_ok & (link.op == acs_op_div);

  // Restoring division, several quotient bits per cycle, 60 bits in all.
  always_comb
  begin
    next_rem = rem;
    next_quo = quo;
    for (int j = 0; j < `ACS_DIV_BITS; j++)
    begin
      if (next_rem >= {1'b0, dvsr})
      begin
        next_rem = next_rem - {1'b0, dvsr};
        next_quo = {next_quo[58:0], 1'b1};
      end
      else
        next_quo = {next_quo[58:0], 1'b0};
      next_rem = {next_rem[52:0], 1'b0};
    end
  end

  always_comb
  begin
    if (dinf)
      div_r = {dsign, 11'h7ff, 52'h0};
    else if (dzero)
      div_r = {dsign, 63'h0};
    else if (quo[59])
      div_r = acs_pack(dsign, dexp, {quo[59:5], |{quo[4:0], rem}}, dnear);
    else
      div_r = acs_pack(dsign, dexp - 14'sh1, {quo[58:4], |{quo[3:0], rem}}, dnear);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      div_cnt <= 8'h0;
      rem <= 54'h0;
      quo <= 60'h0;
      dvsr <= 53'h0;
      dsign <= 1'b0;
      dzero <= 1'b0;
      dinf <= 1'b0;
      dnear <= 1'b0;
      dexp <= 14'sh0;
    end
    else if (div_start)
    begin
      div_cnt <= `ACS_DIV_CYCLES + 8'h1;
      rem <= {1'b0, opa[62:52] != 11'h0, opa[51:0]};
      quo <= 60'h0;
      dvsr <= {1'b1, opb[51:0]};
      dsign <= opa[63] ^ opb[63];
      dzero <= opa[62:52] == 11'h0;
      dinf <= opb[62:52] == 11'h0;
      dnear <= nearest;
      dexp <= $signed({3'h0, opa[62:52]}) - $signed({3'h0, opb[62:52]}) + `ACS_EXP_BIAS;
    end
    else if (div_cnt > 8'h1)
    begin
      div_cnt <= div_cnt - 8'h1;
      rem <= next_rem;
      quo <= next_quo;
    end
    else if (div_last)
      div_cnt <= 8'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      link.ready <= 1'b1;
      link.res_valid <= 1'b0;
      link.result <= 64'h0;
      link.gt <= 1'b0;
      link.lt <= 1'b0;
      constant_holding_register <= 64'h0;
      o_cfg_err <= 1'b0;
    end
    else
    begin
      link.res_valid <= take & pipe_ok & (link.op inside {acs_op_mul, acs_op_add, acs_op_sub});
      if (take && !pipe_ok)
        o_cfg_err <= 1'b1;
      if (div_start)
        link.ready <= 1'b0;
      if (div_last)
      begin
        link.result <= div_r;
        link.res_valid <= 1'b1;
        link.ready <= 1'b1;
      end
      if (take && pipe_ok && link.op inside {acs_op_cmp, acs_op_cmp_abs})
      begin
        link.gt <= cmp_gt;
        link.lt <= cmp_lt;
      end
      if (take && pipe_ok && link.op inside {acs_op_mul, acs_op_add, acs_op_sub})
      begin
        link.result <= alu_r;
        if (link.load_const)
          constant_holding_register <= alu_r;
      end
    end
  end
endmodule : acs_fpu_end

/* File: logic/acs_seq_end.sv */
// Controller end: issues the arctangent instruction sequence and branches on compare results.
`include "acs_defs.svh"
module acs_seq_end
  import acs_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic [63:0] i_x,
  acs_link_if.ctl          link,
  output logic [63:0]      o_result,
  output logic             o_done,
  output logic             o_busy,
  output logic             o_overrun,
  output logic [7:0]       o_cycles
);
  typedef enum logic [4:0] {
    st_idle, st_cmp_in, st_br_in, st_div, st_div_wait, st_pre_m1, st_pre_m2, st_pre_sub,
    st_core_m0, st_core_add, st_core_mul, st_post_mul, st_cmp_hi, st_br_hi, st_cmp_lo, st_br_lo,
    st_fin_sub, st_done
  } acs_seq_state_t;

  function automatic logic [63:0] acs_coef(input logic [4:0] idx);
    case (idx)
      5'h00: return `ACS_C0;
      5'h01: return `ACS_C1;
      5'h02: return `ACS_C2;
      5'h03: return `ACS_C3;
      5'h04: return `ACS_C4;
      5'h05: return `ACS_C5;
      5'h06: return `ACS_C6;
      5'h07: return `ACS_C7;
      5'h08: return `ACS_C8;
      5'h09: return `ACS_C9;
      5'h0a: return `ACS_C10;
      5'h0b: return `ACS_C11;
      5'h0c: return `ACS_C12;
      5'h0d: return `ACS_C13;
      5'h0e: return `ACS_C14;
      5'h0f: return `ACS_C15;
      5'h10: return `ACS_C16;
      5'h11: return `ACS_C17;
      5'h12: return `ACS_C18;
      5'h13: return `ACS_C19;
      default: return 64'h0;
    endcase
  endfunction : acs_coef

  acs_seq_state_t state;
  acs_seq_state_t next_state;
  logic [63:0]    x;
  logic [63:0]    x1;
  logic [63:0]    next_x;
  logic [63:0]    next_x1;
  logic [4:0]     k;
  logic [4:0]     next_k;
  logic [7:0]     cyc;
  logic           acc;
  logic           next_valid;
  acs_op_t        next_op;
  acs_sel_t       next_sel_a;
  acs_sel_t       next_sel_b;
  logic           next_load;
  logic [63:0]    next_da;
  logic [63:0]    next_db;

  assign acc = link.valid & link.ready;
  assign next_x = (state == st_idle && i_start) ? i_x : x;

  always_comb
  begin
    next_state = state;
    next_x1 = x1;
    next_k = k;
    unique case (state)
      st_idle:     if (i_start) next_state = st_cmp_in;
      st_cmp_in:   if (acc) next_state = st_br_in;
      st_br_in:
      begin
        next_state = link.gt ? st_div : st_pre_m1;
        if (!link.gt)
          next_x1 = x;
      end
      st_div:      if (acc) next_state = st_div_wait;
      st_div_wait:
      begin
        if (link.res_valid)
        begin
          next_x1 = link.result;
          next_state = st_pre_m1;
        end
      end
      st_pre_m1:   if (acc) next_state = st_pre_m2;
      st_pre_m2:   if (acc) next_state = st_pre_sub;
      st_pre_sub:  if (acc) next_state = st_core_m0;
      st_core_m0:
      begin
        if (acc)
        begin
          next_state = st_core_add;
          next_k = `ACS_TOP_COEF - 5'h1;
        end
      end
      st_core_add: if (acc) next_state = (k == 5'h0) ? st_post_mul : st_core_mul;
      st_core_mul:
      begin
        if (acc)
        begin
          next_state = st_core_add;
          next_k = k - 5'h1;
        end
      end
      st_post_mul: if (acc) next_state = st_cmp_hi;
      st_cmp_hi:   if (acc) next_state = st_br_hi;
      st_br_hi:    next_state = link.gt ? st_fin_sub : st_cmp_lo;
      st_cmp_lo:   if (acc) next_state = st_br_lo;
      st_br_lo:    next_state = link.lt ? st_fin_sub : st_done;
      st_fin_sub:  if (acc) next_state = st_done;
      st_done:     next_state = st_idle;
    endcase
  end

  always_comb
  begin
    next_valid = 1'b1;
    next_op = acs_op_nop;
    next_sel_a = acs_sel_bus;
    next_sel_b = acs_sel_bus;
    next_load = 1'b0;
    next_da = 64'h0;
    next_db = 64'h0;
    unique case (next_state)
      st_idle, st_br_in, st_div_wait, st_br_hi, st_br_lo, st_done: next_valid = 1'b0;
      st_cmp_in:   begin next_op = acs_op_cmp_abs; next_da = next_x; next_db = `ACS_ONE; end
      st_div:      begin next_op = acs_op_div; next_da = `ACS_ONE; next_db = x; end
      st_pre_m1:   begin next_op = acs_op_mul; next_da = next_x1; next_db = `ACS_TWO; end
      st_pre_m2:   begin next_op = acs_op_mul; next_sel_a = acs_sel_res; next_db = x1; end
      st_pre_sub:
      begin
        next_op = acs_op_sub;
        next_sel_a = acs_sel_res;
        next_db = `ACS_ONE;
        next_load = 1'b1;
      end
      st_core_m0:  begin next_op = acs_op_mul; next_da = acs_coef(`ACS_TOP_COEF); next_sel_b = acs_sel_const; end
      st_core_add: begin next_op = acs_op_add; next_sel_a = acs_sel_res; next_db = acs_coef(next_k); end
      st_core_mul: begin next_op = acs_op_mul; next_sel_a = acs_sel_res; next_sel_b = acs_sel_const; end
      st_post_mul: begin next_op = acs_op_mul; next_sel_a = acs_sel_res; next_db = x1; end
      st_cmp_hi:   begin next_op = acs_op_cmp; next_da = x; next_db = `ACS_ONE; end
      st_cmp_lo:   begin next_op = acs_op_cmp; next_da = x; next_db = `ACS_NEG_ONE; end
      st_fin_sub:
      begin
        next_op = acs_op_sub;
        next_da = (state == st_br_hi) ? `ACS_HALF_PI : `ACS_NEG_HALF_PI;
        next_sel_b = acs_sel_res;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= st_idle;
      x <= 64'h0;
      x1 <= 64'h0;
      k <= 5'h0;
      link.valid <= 1'b0;
      link.op <= acs_op_nop;
      link.sel_a <= acs_sel_bus;
      link.sel_b <= acs_sel_bus;
      link.load_const <= 1'b0;
      link.data_a <= 64'h0;
      link.data_b <= 64'h0;
    end
    else
    begin
      state <= next_state;
      x <= next_x;
      x1 <= next_x1;
      k <= next_k;
      if (next_state != state)
      begin
        link.valid <= next_valid;
        link.op <= next_op;
        link.sel_a <= next_sel_a;
        link.sel_b <= next_sel_b;
        link.load_const <= next_load;
        link.data_a <= next_da;
        link.data_b <= next_db;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      link.pipeline_stage_select <= `ACS_PIPE_SEL;
      link.rounding_select <= `ACS_ROUND_NEAREST;
      cyc <= 8'h0;
      o_result <= 64'h0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_overrun <= 1'b0;
      o_cycles <= 8'h0;
    end
    else
    begin
      o_busy <= next_state != st_idle;
      o_done <= state == st_done;
      if (state == st_idle)
        cyc <= 8'h0;
      else if (cyc != 8'hff)
        cyc <= cyc + 8'h1;
      if (state == st_done)
      begin
        o_result <= link.result;
        o_cycles <= cyc;
        o_overrun <= cyc > `ACS_TOTAL_CYCLES;
      end
    end
  end
endmodule : acs_seq_end

/* File: testbench/acs_link_monitor.sv */
// Concurrent checks on the link between the controller end and the floating point end.
`include "acs_defs.svh"
module acs_link_monitor
  import acs_pkg::*;
(
  input logic        i_clk,
  input logic        i_rst,
  input logic        valid,
  input acs_op_t     op,
  input acs_sel_t    sel_a,
  input logic [63:0] data_a,
  input logic [2:0]  pipeline_stage_select,
  input logic [1:0]  rounding_select,
  input logic        ready,
  input logic        res_valid,
  input logic [63:0] result,
  input logic        gt,
  input logic        lt
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  wire take   = valid && ready;
  wire arith  = (op == acs_op_mul) || (op == acs_op_add) || (op == acs_op_sub);
  wire is_cmp = (op == acs_op_cmp) || (op == acs_op_cmp_abs);
  wire sub_a  = take && (op == acs_op_sub) && (sel_a == acs_sel_bus);

  // A divide holds the unit busy for sixteen cycles and finishes in the seventeenth.
  sequence div_wait_s;
    (!ready)[*8] ##1 (!ready)[*8];
  endsequence
  sequence div_done_s;
    ready && res_valid;
  endsequence

  cfg_fixed_a: assert property (
    valid |-> pipeline_stage_select == `ACS_PIPE_SEL && rounding_select == `ACS_ROUND_NEAREST)
    else $error("link configuration is not the fixed one");
  res_after_op_a: assert property (take && arith |=> res_valid)
    else $error("arithmetic result did not follow the take");
  div_latency_a: assert property (take && op == acs_op_div |=> div_wait_s ##1 div_done_s)
    else $error("divide latency wrong");
  cmp_quiet_a: assert property (take && is_cmp |=> !res_valid && $stable(result))
    else $error("compare disturbed the result");
  flags_excl_a: assert property (!(gt && lt))
    else $error("both compare flags set");
  result_hold_a: assert property (!res_valid && !$past(i_rst) |-> $stable(result))
    else $error("result changed without a result pulse");
  div_path_a: assert property (take && op == acs_op_div |-> gt)
    else $error("reciprocal taken without magnitude above one");
  pos_quad_a: assert property (sub_a && data_a == `ACS_HALF_PI |-> gt && !lt)
    else $error("positive quadrant correction without input above one");
  neg_quad_a: assert property (sub_a && data_a == `ACS_NEG_HALF_PI |-> lt && !gt)
    else $error("negative quadrant correction without input below minus one");

  div_seen_c: cover property (take && op == acs_op_div);
endmodule : acs_link_monitor

/* File: testbench/arctangent_chebyshev_sequencer_tb.sv */
// Self-checking bench with the controller end and the floating point end joined on one link.
`include "acs_defs.svh"
module arctangent_chebyshev_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk   = 1'b0;
  logic        i_rst   = 1'b1;
  logic        i_start = 1'b0;
  logic [63:0] i_x     = 64'h0;
  logic [63:0] o_result;
  logic        o_done;
  logic        o_busy;
  logic        o_overrun;
  logic [7:0]  o_cycles;
  logic [63:0] const_reg;
  logic        cfg_err;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          seed       = 43;
  int          cycles     = 0;
  logic [63:0] coef [20]  = '{`ACS_C0, `ACS_C1, `ACS_C2, `ACS_C3, `ACS_C4, `ACS_C5, `ACS_C6, `ACS_C7,
                              `ACS_C8, `ACS_C9, `ACS_C10, `ACS_C11, `ACS_C12, `ACS_C13, `ACS_C14,
                              `ACS_C15, `ACS_C16, `ACS_C17, `ACS_C18, `ACS_C19};
  logic [63:0] corner [9] = '{`ACS_ONE, `ACS_NEG_ONE, 64'h0, `ACS_TWO, 64'hc000000000000000,
                              64'h3ff0000000000001, 64'hbff0000000000001, 64'h412e848000000000,
                              64'h3fe0000000000000};

  acs_link_if link_bus ();

  acs_fpu_end acs_fpu_end_inst (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .link        (link_bus.dev),
    .o_const_reg (const_reg),
    .o_cfg_err   (cfg_err)
  );

  acs_seq_end acs_seq_end_inst (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_start   (i_start),
    .i_x       (i_x),
    .link      (link_bus.ctl),
    .o_result  (o_result),
    .o_done    (o_done),
    .o_busy    (o_busy),
    .o_overrun (o_overrun),
    .o_cycles  (o_cycles)
  );

  acs_link_monitor acs_link_monitor_inst (
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .valid                 (link_bus.valid),
    .op                    (link_bus.op),
    .sel_a                 (link_bus.sel_a),
    .data_a                (link_bus.data_a),
    .pipeline_stage_select (link_bus.pipeline_stage_select),
    .rounding_select       (link_bus.rounding_select),
    .ready                 (link_bus.ready),
    .res_valid             (link_bus.res_valid),
    .result                (link_bus.result),
    .gt                    (link_bus.gt),
    .lt                    (link_bus.lt)
  );

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  // Working value: the reciprocal when the magnitude exceeds one, else the input.
  function automatic real x1_ref(input real x);
    return (x > 1.0 || x < -1.0) ? 1.0 / x : x;
  endfunction : x1_ref

  // Works out the arctangent step by step in the order the routine prescribes.
  function automatic real atan_ref(input real x);
    real x1;
    real a;
    real p;
    x1 = x1_ref(x);
    a = 2.0 * x1 * x1 - 1.0;
    p = $bitstoreal(coef[19]);
    for (int k = 18; k >= 0; k--)
      p = p * a + $bitstoreal(coef[k]);
    p = p * x1;
    if (x > 1.0)
      return $bitstoreal(`ACS_HALF_PI) - p;
    if (x < -1.0)
      return $bitstoreal(`ACS_NEG_HALF_PI) - p;
    return p;
  endfunction : atan_ref

  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Runs one evaluation; with poke set a second start is offered while busy and must be ignored.
  task automatic run_one(input logic [63:0] x, input bit poke);
    real diff;
    real w;
    int  n;
    @(posedge i_clk);
    #1;
    i_start = 1'b1;
    i_x = x;
    @(posedge i_clk);
    #1;
    i_start = poke;
    i_x = `ACS_TWO;
    check(o_busy === 1'b1, "busy not raised after start");
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 300)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(n < 300, "run never completed");
    diff = $bitstoreal(o_result) - atan_ref($bitstoreal(x));
    check(!$isunknown(o_result) && diff < 1e-10 && diff > -1e-10, "arctangent value off");
    w = x1_ref($bitstoreal(x));
    diff = $bitstoreal(const_reg) - (2.0 * w * w - 1.0);
    check(!$isunknown(const_reg) && diff < 1e-12 && diff > -1e-12, "series argument not held");
    check(o_overrun === 1'b0 && o_cycles <= 8'h68, "run longer than allowed");
    check(cfg_err === 1'b0, "link configuration refused");
  endtask : run_one

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("unexpected at %0t: run hung", $time);
      complete_run();
    end
  end

  initial
  begin
    real r;
    repeat (6) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    foreach (corner[i])
      run_one(corner[i], i == 3);
    repeat (12)
    begin
      r = $itor($random(seed) % 5000) / 97.0;
      run_one($realtobits(r), 1'b0);
      r = $itor($random(seed) % 1000) / 1000.0;
      run_one($realtobits(r), 1'b0);
    end
    @(posedge i_clk);
    #1;
    i_start = 1'b1;
    i_x = `ACS_TWO;
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    repeat (20) @(posedge i_clk);
    #1;
    i_rst = 1'b1;
    @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    check(o_busy === 1'b0 && link_bus.valid === 1'b0, "reset did not abort the run");
    run_one(64'hc000000000000000, 1'b0);
    complete_run();
  end
endmodule : arctangent_chebyshev_sequencer_tb
